// ==== src/ccs_regs.svh ====
/*
  ccs_regs.svh: register offsets, field positions, reset values and timing
  figures of the charge cycle state controller.
  Assumes a 50 MHz clock and a Wishbone bus with byte addresses.
*/
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// clock rate
`define CCS_CLK_MHZ 50
`define CCS_CLK_HZ (`CCS_CLK_MHZ * 1000000)

// termination comparator filter, in microseconds
`define CCS_TERM_FILTER_US 1000
`define CCS_TERM_FILTER_CYCLES (`CCS_TERM_FILTER_US * `CCS_CLK_MHZ)
// half period of the supply-good probe pulse, in microseconds
`define CCS_PROBE_HALF_US 10000
`define CCS_PROBE_HALF_CYCLES (`CCS_PROBE_HALF_US * `CCS_CLK_MHZ)
// safety timer
`define CCS_SEC_PER_HOUR 3600
`define CCS_TIMER_HOURS_DEF 6

// register byte offsets
`define CCS_REG_CTRL 8'h00
`define CCS_REG_STATUS 8'h04
`define CCS_REG_TIMER 8'h08

// control register fields and reset value
`define CCS_CTRL_SOFT_DISABLE 0
`define CCS_CTRL_TIMER_OFF 1
`define CCS_CTRL_RESET 2'h0

// status register fields
`define CCS_STAT_STATE_LSB 0
`define CCS_STAT_CHARGED 9
`define CCS_STAT_TIMER_RUN 10
`define CCS_STAT_SOURCE_AC 11
`define CCS_STAT_ENABLED 12

// build-time current ratios, in percent of the fast-charge current
`define CCS_PRECOND_PCT_DEF 10
`define CCS_TERM_PCT_DEF 7
`define CCS_FULL_PCT 100

`endif

// ==== src/ccs_pkg.sv ====
/*
  ccs_pkg: types of the charge cycle state controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ccs_pkg;

  typedef enum logic [8:0] {
    CCS_SHUTDOWN    = 9'b0_0000_0001,
    CCS_STANDBY     = 9'b0_0000_0010,
    CCS_PRECOND     = 9'b0_0000_0100,
    CCS_CONST_CURR  = 9'b0_0000_1000,
    CCS_CONST_VOLT  = 9'b0_0001_0000,
    CCS_COMPLETE    = 9'b0_0010_0000,
    CCS_TEMP_FAULT  = 9'b0_0100_0000,
    CCS_TIMER_FAULT = 9'b0_1000_0000,
    CCS_TEST        = 9'b1_0000_0000
  } ccs_state_t;

  // index of each comparator bit in the synchronised vector
  typedef enum int unsigned {
    CCS_IN_SUPPLY_VALID = 0,
    CCS_IN_ABOVE_REG    = 1,
    CCS_IN_AC_PRESENT   = 2,
    CCS_IN_THERMISTOR_INPUT_HIGH   = 3,
    CCS_IN_THERMISTOR_INPUT_LOW    = 4,
    CCS_IN_THERMISTOR_INPUT_TEST   = 5,
    CCS_IN_BATTERY      = 6,
    CCS_IN_BELOW_PRE    = 7,
    CCS_IN_AT_REG       = 8,
    CCS_IN_BELOW_RECHG  = 9,
    CCS_IN_TERM_CURR    = 10,
    CCS_IN_SET_OPEN     = 11,
    CCS_IN_USB_RANGE    = 12,
    CCS_IN_TIMER_EN_N   = 13,
    CCS_IN_COUNT        = 14
  } ccs_input_t;

endpackage

// ==== src/ccs_charge_ctrl.sv ====
/*
  ccs_charge_ctrl: charge cycle sequencer of a linear lithium-cell charger,
  with status open-drain outputs, safety timer and a Wishbone register slave.
  Assumes comparator results arrive asynchronously from the analog section,
  a 50 MHz clock, a synchronous active-high reset tied to lockout release,
  and a classic single-cycle Wishbone master.
*/
// What this block does
// RL1 - supply below lockout or within 100 mV of battery forces power-down
// RL2 - thermistor outside 0.25V to 1.20V window suspends charging at once
// RL3 - while suspended, pass transistor off, timer frozen, resume when back inside
// RL4 - thermistor above supply minus 100 mV with no battery enters system test
// RL5 - system test regulates at set voltage, current limit equals fast charge
// RL6 - leave system test only on thermistor release or power cycling
// RL7 - thermistor bias off in shutdown, standby and system test
// RL8 - thermistor pull-down only in standby and system test
// RL9 - status outputs only pull low or float, never drive high
// RL10 - shutdown all float; standby and faults: charge outputs float, supply-good low
// RL11 - precondition, constant current, constant voltage: first low, second floats, supply-good low
// RL12 - complete: first floats, others low; system test all three low
// RL13 - usb range select low picks 100 mA limit, high picks 500 mA
// RL14 - supply-good low when supply above lockout and above battery
// RL15 - supply below regulation plus 0.3V pulses supply-good while probing battery
// RL16 - timer enable input low runs the safety timer, high stops it
// RL17 - supply-good output and timer enable input are exclusive build options
// RL18 - current-set open or high disables device, ending any cycle
// RL19 - re-enable starts a new cycle, or recharge if already charged
// RL20 - precondition and termination currents are build-time ratios of fast charge
// RL21 - constant voltage ends on 1 ms filtered termination or timer expiry
// RL22 - timer expiry in fast charge latches timer fault until battery, set or power
// RL23 - in complete, battery below recharge threshold starts a new cycle
// RL24 - adapter preferred over usb; timer keeps counting across switch-over
// RL25 - every comparator result is synchronised before it steers transitions
// RL26 - safety timer period is a parameter on a prescaled clock, may be removed
`timescale 1ns/1ps
`include "ccs_regs.svh"

module ccs_charge_ctrl
  import ccs_pkg::*;
#(
  parameter int unsigned TIMER_HOURS = `CCS_TIMER_HOURS_DEF,
  parameter int unsigned SEC_CYCLES = `CCS_CLK_HZ,
  parameter int unsigned TERM_FILTER_CYCLES = `CCS_TERM_FILTER_CYCLES,
  parameter int unsigned PROBE_HALF_CYCLES = `CCS_PROBE_HALF_CYCLES,
  parameter bit HAS_SUPPLY_GOOD = 1'b1,
  parameter logic [7:0] PRECOND_PCT = 8'(`CCS_PRECOND_PCT_DEF),
  parameter logic [7:0] TERM_PCT = 8'(`CCS_TERM_PCT_DEF)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // analog comparator results, asynchronous
  input wire logic supply_valid_i,
  input wire logic supply_above_reg_i,
  input wire logic ac_present_i,
  input wire logic thermistor_input_high_i,
  input wire logic thermistor_input_low_i,
  input wire logic thermistor_input_test_i,
  input wire logic battery_present_i,
  input wire logic vbat_below_precond_i,
  input wire logic vbat_at_reg_i,
  input wire logic vbat_below_recharge_i,
  input wire logic term_current_i,
  // user pins, asynchronous
  input wire logic current_set_open_i,
  input wire logic usb_range_select_i,
  input wire logic safety_timer_enable_n_i,
  // analog controls
  output logic pass_enable_o,
  output logic source_ac_o,
  output logic usb_high_range_o,
  output logic ldo_mode_o,
  output logic [7:0] current_ratio_o,
  output logic [7:0] term_ratio_o,
  output logic thermistor_bias_current_en_o,
  output logic thermistor_input_pulldown_en_o,
  output logic timer_run_o,
  // open-drain status pins
  output logic charging_indicator_o,
  output logic charging_indicator_oe_n_o,
  output logic done_indicator_o,
  output logic done_indicator_oe_n_o,
  output logic supply_good_out_o,
  output logic supply_good_out_oe_n_o
);

  localparam int CW = 26;
  localparam int N = CCS_IN_COUNT;
  localparam logic [15:0] TIMER_LIMIT = 16'(TIMER_HOURS * `CCS_SEC_PER_HOUR);
  localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYCLES - 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(TERM_FILTER_CYCLES - 1);
  localparam logic [CW-1:0] PROBE_LAST = CW'(PROBE_HALF_CYCLES - 1);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] filt;
    ccs_state_t state;
    ccs_state_t resume;
    logic charged;
    logic [CW-1:0] presc;
    logic [15:0] timer;
    logic [CW-1:0] filt_cnt;
    logic [CW-1:0] probe_cnt;
    logic probe_low;
    logic [1:0] ctrl;
    logic ack;
    logic [31:0] dat;
    logic pass_en;
    logic src_ac;
    logic usb_high;
    logic ldo;
    logic [7:0] ratio;
    logic bias_en;
    logic pd_en;
    logic timer_run;
    logic chg_oe_n;
    logic done_oe_n;
    logic pg_oe_n;
  } ccs_regs_t;

  ccs_regs_t st_reg;
  ccs_regs_t st_next;

  logic [N-1:0] raw_in;
  assign raw_in = {safety_timer_enable_n_i, usb_range_select_i, current_set_open_i, term_current_i,
                   vbat_below_recharge_i, vbat_at_reg_i, vbat_below_precond_i, battery_present_i,
                   thermistor_input_test_i, thermistor_input_low_i, thermistor_input_high_i, ac_present_i, supply_above_reg_i,
                   supply_valid_i};

  always_comb begin
    logic [N-1:0] agree;
    logic supply_ok;
    logic batt;
    logic enabled;
    logic thermistor_input_bad;
    logic test_req;
    logic timer_on;
    logic timer_done;
    logic active;
    logic sec_tick;
    logic wb_req;
    ccs_state_t start_st;
    agree = '0;
    supply_ok = 1'b0;
    batt = 1'b0;
    enabled = 1'b0;
    thermistor_input_bad = 1'b0;
    test_req = 1'b0;
    timer_on = 1'b0;
    timer_done = 1'b0;
    active = 1'b0;
    sec_tick = 1'b0;
    wb_req = 1'b0;
    start_st = CCS_PRECOND;
    st_next = st_reg;

    // three stages; a change counts once the last two agree
    st_next.s1 = raw_in; // RL25
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.filt = (st_reg.s3 & agree) | (st_reg.filt & ~agree); // RL25

    supply_ok = st_reg.filt[CCS_IN_SUPPLY_VALID];
    batt = st_reg.filt[CCS_IN_BATTERY];
    enabled = !st_reg.filt[CCS_IN_SET_OPEN] && !st_reg.ctrl[`CCS_CTRL_SOFT_DISABLE]; // RL18
    thermistor_input_bad = st_reg.filt[CCS_IN_THERMISTOR_INPUT_HIGH] || st_reg.filt[CCS_IN_THERMISTOR_INPUT_LOW]; // RL2
    test_req = st_reg.filt[CCS_IN_THERMISTOR_INPUT_TEST] && !batt; // RL4
    // timer pin exists only on the variant without supply-good
    timer_on = (TIMER_HOURS != 0) && !st_reg.ctrl[`CCS_CTRL_TIMER_OFF] &&
               (HAS_SUPPLY_GOOD || !st_reg.filt[CCS_IN_TIMER_EN_N]); // RL16 RL17 RL26
    timer_done = timer_on && (st_reg.timer >= TIMER_LIMIT);
    start_st = st_reg.filt[CCS_IN_BELOW_PRE] ? CCS_PRECOND : CCS_CONST_CURR;
    active = (st_reg.state == CCS_PRECOND) || (st_reg.state == CCS_CONST_CURR) ||
             (st_reg.state == CCS_CONST_VOLT);

    // prescaled safety timer; frozen outside active charge
    if (active && timer_on) begin
      sec_tick = (st_reg.presc == SEC_LAST);
      st_next.presc = sec_tick ? '0 : st_reg.presc + CW'(1); // RL26
      if (sec_tick && !timer_done) begin
        st_next.timer = st_reg.timer + 16'h0001; // RL24
      end
    end

    // termination filter counts only an unbroken assertion in constant voltage
    if (st_reg.state == CCS_CONST_VOLT && st_reg.filt[CCS_IN_TERM_CURR]) begin
      if (st_reg.filt_cnt != FILT_LAST) begin
        st_next.filt_cnt = st_reg.filt_cnt + CW'(1); // RL21
      end
    end else begin
      st_next.filt_cnt = '0;
    end

    case (st_reg.state)
      CCS_SHUTDOWN: begin
        if (supply_ok) begin
          st_next.state = CCS_STANDBY;
        end
      end
      CCS_STANDBY: begin
        if (test_req) begin
          st_next.state = CCS_TEST; // RL4
        end else if (batt && enabled) begin
          if (st_reg.charged) begin
            st_next.state = CCS_COMPLETE; // RL19
          end else begin
            st_next.state = start_st; // RL19
            st_next.timer = '0;
            st_next.presc = '0;
          end
        end
      end
      CCS_PRECOND, CCS_CONST_CURR, CCS_CONST_VOLT: begin
        if (!batt || !enabled) begin
          st_next.state = CCS_STANDBY; // RL18
          st_next.charged = st_reg.charged && batt;
        end else if (thermistor_input_bad) begin
          st_next.state = CCS_TEMP_FAULT; // RL2
          st_next.resume = st_reg.state; // RL3
        end else if (st_reg.state == CCS_PRECOND) begin
          if (timer_done) begin
            st_next.state = CCS_TIMER_FAULT;
          end else if (!st_reg.filt[CCS_IN_BELOW_PRE]) begin
            st_next.state = CCS_CONST_CURR;
            st_next.timer = '0; // timer restarts on fast charge entry
            st_next.presc = '0;
          end
        end else if (st_reg.state == CCS_CONST_CURR) begin
          if (timer_done) begin
            st_next.state = CCS_TIMER_FAULT; // RL22
          end else if (st_reg.filt[CCS_IN_AT_REG]) begin
            st_next.state = CCS_CONST_VOLT;
          end
        end else if (timer_done || st_reg.filt_cnt == FILT_LAST) begin
          st_next.state = CCS_COMPLETE; // RL21
          st_next.charged = 1'b1;
        end
      end
      CCS_TEMP_FAULT: begin
        if (!batt || !enabled) begin
          st_next.state = CCS_STANDBY;
        end else if (!thermistor_input_bad) begin
          st_next.state = st_reg.resume; // RL3
        end
      end
      CCS_TIMER_FAULT: begin
        if (!batt || !enabled) begin
          st_next.state = CCS_STANDBY; // RL22
        end
      end
      CCS_COMPLETE: begin
        if (!batt) begin
          st_next.state = CCS_STANDBY;
          st_next.charged = 1'b0;
        end else if (!enabled) begin
          st_next.state = CCS_STANDBY; // RL18
        end else if (st_reg.filt[CCS_IN_BELOW_RECHG]) begin
          st_next.state = start_st; // RL23
          st_next.timer = '0;
          st_next.presc = '0;
        end
      end
      CCS_TEST: begin
        if (!st_reg.filt[CCS_IN_THERMISTOR_INPUT_TEST]) begin
          st_next.state = CCS_STANDBY; // RL6
        end
      end
      default: begin
        st_next.state = CCS_SHUTDOWN;
      end
    endcase

    // lockout wins over every other transition, including test mode
    if (!supply_ok) begin
      st_next.state = CCS_SHUTDOWN; // RL1
      st_next.charged = 1'b0;
    end

    // battery probe pulse while supply sits below regulation plus margin
    if (st_next.state == CCS_STANDBY && !st_reg.filt[CCS_IN_ABOVE_REG]) begin
      if (st_reg.probe_cnt == PROBE_LAST) begin
        st_next.probe_cnt = '0;
        st_next.probe_low = !st_reg.probe_low; // RL15
      end else begin
        st_next.probe_cnt = st_reg.probe_cnt + CW'(1);
      end
    end else begin
      st_next.probe_cnt = '0;
      st_next.probe_low = 1'b1;
    end

    // state outputs decoded from the next state so the pins follow it in the same edge
    st_next.pass_en = (st_next.state == CCS_PRECOND) || (st_next.state == CCS_CONST_CURR) ||
                      (st_next.state == CCS_CONST_VOLT) || (st_next.state == CCS_TEST); // RL3
    st_next.ldo = (st_next.state == CCS_TEST); // RL5
    st_next.ratio = (st_next.state == CCS_PRECOND) ? PRECOND_PCT : 8'(`CCS_FULL_PCT); // RL20 RL5
    st_next.src_ac = st_reg.filt[CCS_IN_AC_PRESENT]; // RL24
    st_next.usb_high = st_reg.filt[CCS_IN_USB_RANGE]; // RL13
    st_next.timer_run = timer_on &&
                        ((st_next.state == CCS_PRECOND) || (st_next.state == CCS_CONST_CURR) ||
                         (st_next.state == CCS_CONST_VOLT));
    st_next.bias_en = !((st_next.state == CCS_SHUTDOWN) || (st_next.state == CCS_STANDBY) ||
                        (st_next.state == CCS_TEST)); // RL7
    st_next.pd_en = (st_next.state == CCS_STANDBY) || (st_next.state == CCS_TEST); // RL8
    st_next.chg_oe_n = !((st_next.state == CCS_PRECOND) || (st_next.state == CCS_CONST_CURR) ||
                         (st_next.state == CCS_CONST_VOLT) || (st_next.state == CCS_TEST)); // RL10 RL11
    st_next.done_oe_n = !((st_next.state == CCS_COMPLETE) || (st_next.state == CCS_TEST)); // RL12
    st_next.pg_oe_n = !(HAS_SUPPLY_GOOD && (st_next.state != CCS_SHUTDOWN) &&
                        st_next.probe_low); // RL14 RL15 RL17

    // single-cycle slave: ack one cycle after the request, writes land on the edge that ends the ack cycle
    wb_req = cyc_i && stb_i;
    st_next.ack = wb_req && !st_reg.ack;
    if (wb_req && st_reg.ack && we_i && sel_i[0] && adr_i == `CCS_REG_CTRL) begin
      st_next.ctrl = dat_i[1:0];
    end
    if (wb_req && !st_reg.ack) begin
      case (adr_i)
        `CCS_REG_CTRL: st_next.dat = {30'h0000_0000, st_reg.ctrl};
        `CCS_REG_STATUS: st_next.dat = {19'h0_0000, enabled, st_reg.filt[CCS_IN_AC_PRESENT],
                                        st_reg.timer_run, st_reg.charged, st_reg.state};
        `CCS_REG_TIMER: st_next.dat = {16'h0000, st_reg.timer};
        default: st_next.dat = 32'h0000_0000;
      endcase
    end else begin
      st_next.dat = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.state <= CCS_SHUTDOWN;
      st_reg.resume <= CCS_PRECOND;
      st_reg.ctrl <= `CCS_CTRL_RESET;
      st_reg.probe_low <= 1'b1;
      st_reg.ratio <= 8'(`CCS_FULL_PCT);
      st_reg.chg_oe_n <= 1'b1;
      st_reg.done_oe_n <= 1'b1;
      st_reg.pg_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dat_o = st_reg.dat;
  assign ack_o = st_reg.ack;
  assign pass_enable_o = st_reg.pass_en;
  assign source_ac_o = st_reg.src_ac;
  assign usb_high_range_o = st_reg.usb_high;
  assign ldo_mode_o = st_reg.ldo;
  assign current_ratio_o = st_reg.ratio;
  assign term_ratio_o = TERM_PCT; // RL20
  assign thermistor_bias_current_en_o = st_reg.bias_en;
  assign thermistor_input_pulldown_en_o = st_reg.pd_en;
  assign timer_run_o = st_reg.timer_run;
  // open-drain pins only ever pull low
  assign charging_indicator_o = 1'b0; // RL9
  assign charging_indicator_oe_n_o = st_reg.chg_oe_n;
  assign done_indicator_o = 1'b0; // RL9
  assign done_indicator_oe_n_o = st_reg.done_oe_n;
  assign supply_good_out_o = 1'b0; // RL9
  assign supply_good_out_oe_n_o = st_reg.pg_oe_n;

endmodule // ccs_charge_ctrl

// ==== dv/ccs_charge_ctrl_sva.sv ====
/*
  ccs_charge_ctrl_sva: concurrent checks on the charge sequencer ports.
  Assumes the 50 MHz clock domain only and the comparator filter delay
  of five edges from an input step to a state change.
*/
`timescale 1ns/1ps
module ccs_charge_ctrl_sva #(
  parameter logic [7:0] PRECOND_PCT = 8'h0a,
  parameter logic [7:0] TERM_PCT = 8'h07
) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // comparator and pin inputs
  input wire logic supply_valid_i,
  input wire logic supply_above_reg_i,
  input wire logic ac_present_i,
  input wire logic thermistor_input_high_i,
  input wire logic thermistor_input_low_i,
  input wire logic thermistor_input_test_i,
  input wire logic battery_present_i,
  input wire logic current_set_open_i,
  input wire logic usb_range_select_i,
  // controls
  input wire logic pass_enable_o,
  input wire logic source_ac_o,
  input wire logic usb_high_range_o,
  input wire logic ldo_mode_o,
  input wire logic [7:0] current_ratio_o,
  input wire logic [7:0] term_ratio_o,
  input wire logic thermistor_bias_current_en_o,
  input wire logic thermistor_input_pulldown_en_o,
  input wire logic timer_run_o,
  // open-drain status
  input wire logic charging_indicator_o,
  input wire logic charging_indicator_oe_n_o,
  input wire logic done_indicator_o,
  input wire logic done_indicator_oe_n_o,
  input wire logic supply_good_out_o,
  input wire logic supply_good_out_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // long holds are counted here; unrolling them as repetitions costs too much
  logic [3:0] test_cnt;
  logic [3:0] off_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !(thermistor_input_test_i && !battery_present_i && supply_valid_i)) begin
      test_cnt <= 4'h0;
    end else if (test_cnt != 4'hf) begin
      test_cnt <= test_cnt + 4'h1;
    end
    if (rst_i || !(current_set_open_i && !thermistor_input_test_i)) begin
      off_cnt <= 4'h0;
    end else if (off_cnt != 4'hf) begin
      off_cnt <= off_cnt + 4'h1;
    end
  end

  chk_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  chk_od_never_high: assert property (!charging_indicator_o && !done_indicator_o && !supply_good_out_o)
    else $error("status pin driven high");
  chk_supply_loss_down: assert property (!supply_valid_i [*7] |-> charging_indicator_oe_n_o &&
    done_indicator_oe_n_o && supply_good_out_oe_n_o && !pass_enable_o) else $error("no power-down");
  // test mode also raises the high comparator, so it is kept out
  chk_thermistor_input_suspend: assert property (((thermistor_input_high_i || thermistor_input_low_i) && !thermistor_input_test_i) [*7]
    |-> !pass_enable_o && !timer_run_o) else $error("charge not suspended");
  chk_test_entry: assert property (thermistor_input_test_i && !battery_present_i && supply_valid_i && test_cnt >= 4'h8
    |-> ldo_mode_o) else $error("test mode not entered");
  chk_ldo_outputs: assert property (ldo_mode_o |-> pass_enable_o && !charging_indicator_oe_n_o &&
    !done_indicator_oe_n_o && !supply_good_out_oe_n_o && current_ratio_o == 8'h64) else $error("bad test outputs");
  chk_test_hold: assert property (ldo_mode_o && thermistor_input_test_i && supply_valid_i |=> ldo_mode_o)
    else $error("test mode left early");
  chk_pulldown_states: assert property (thermistor_input_pulldown_en_o |-> !thermistor_bias_current_en_o &&
    charging_indicator_oe_n_o == done_indicator_oe_n_o) else $error("pull-down outside standby or test");
  chk_charge_pins: assert property (!charging_indicator_oe_n_o && done_indicator_oe_n_o |-> pass_enable_o &&
    !supply_good_out_oe_n_o && thermistor_bias_current_en_o) else $error("bad charging outputs");
  chk_range_follow: assert property ($stable({usb_range_select_i, ac_present_i}) [*7]
    |-> {usb_high_range_o, source_ac_o} == {usb_range_select_i, ac_present_i}) else $error("range not followed");
  chk_probe_pulse: assert property ($rose(supply_good_out_oe_n_o) && supply_valid_i && !supply_above_reg_i
    |-> ##[1:6] $fell(supply_good_out_oe_n_o)) else $error("probe pulse stuck");
  chk_disable_off: assert property (current_set_open_i && !thermistor_input_test_i && off_cnt >= 4'h8 |-> !pass_enable_o)
    else $error("charging while disabled");
  chk_ratio_fixed: assert property (term_ratio_o == TERM_PCT &&
    (current_ratio_o == 8'h64 || current_ratio_o == PRECOND_PCT)) else $error("bad current ratio");
endmodule // ccs_charge_ctrl_sva

// ==== dv/ccs_batt_model.sv ====
/*
  ccs_batt_model: behavioural cell seen by the charger comparators.
  Assumes one charge step per clock while the pass transistor conducts.
*/
`timescale 1ns/1ps
module ccs_batt_model (
  // control
  input wire logic clk_i,
  input wire logic pass_enable_i,
  input wire logic inserted_i,
  input wire logic stall_i,
  input wire logic drain_i,
  // comparator levels
  output logic battery_present_o,
  output logic below_precond_o,
  output logic at_reg_o,
  output logic below_recharge_o,
  output logic term_current_o
);
  int level = 0;
  // stall models a cell that never reaches regulation
  always @(posedge clk_i) begin
    if (!inserted_i) level <= 0;
    else if (drain_i) level <= 30;
    else if (pass_enable_i && !stall_i && level < 80) level <= level + 1;
  end
  assign battery_present_o = inserted_i;
  assign below_precond_o = level < 10;
  assign at_reg_o = level >= 40;
  assign below_recharge_o = level < 35;
  assign term_current_o = level >= 60;
endmodule // ccs_batt_model

// ==== dv/ccs_charge_ctrl_tb.sv ====
/*
  ccs_charge_ctrl_tb: walks the charge cycle through every state over the bus.
  Assumes shortened timer, filter and probe counts set at the instance.
*/
`timescale 1ns/1ps
module ccs_charge_ctrl_tb;
  import ccs_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic ack_o, supply_valid_i = 1'h0, supply_above_reg_i = 1'h0, ac_present_i = 1'h0;
  logic thermistor_input_high_i = 1'h0, thermistor_input_low_i = 1'h0, thermistor_input_test_i = 1'h0, current_set_open_i = 1'h0;
  logic usb_range_select_i = 1'h0, safety_timer_enable_n_i = 1'h0;
  logic battery_present_i, vbat_below_precond_i, vbat_at_reg_i, vbat_below_recharge_i, term_current_i;
  logic inserted = 1'h0, stall = 1'h0, drain = 1'h0;
  logic pass_enable_o, source_ac_o, usb_high_range_o, ldo_mode_o, thermistor_bias_current_en_o;
  logic thermistor_input_pulldown_en_o, timer_run_o, charging_indicator_o, charging_indicator_oe_n_o;
  logic done_indicator_o, done_indicator_oe_n_o, supply_good_out_o, supply_good_out_oe_n_o;
  logic [7:0] current_ratio_o, term_ratio_o;
  logic [63:0] notes[$];
  logic [63:0] note;
  int num_errors = 0, total_checks = 0, i;
  integer seed = 73975;
  logic [31:0] rnd;

  always #10 clk_i = ~clk_i;

  ccs_charge_ctrl #(.TIMER_HOURS(1), .SEC_CYCLES(2), .TERM_FILTER_CYCLES(8), .PROBE_HALF_CYCLES(4)) i_dut (.*);
  ccs_batt_model i_batt (.clk_i(clk_i), .pass_enable_i(pass_enable_o), .inserted_i(inserted),
    .stall_i(stall), .drain_i(drain), .battery_present_o(battery_present_i),
    .below_precond_o(vbat_below_precond_i), .at_reg_o(vbat_at_reg_i),
    .below_recharge_o(vbat_below_recharge_i), .term_current_o(term_current_i));

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("Error at %0t: %s", $time, msg);
    give_verdict();
  endtask

  // each access leaves a note {mask, expected}; mask zero means not compared
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [31:0] e, output logic [31:0] r);
    int n;
    notes.push_back({m, e});
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    r = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (ack_o !== 1'h1) fail("bus timeout");
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'h0, a, 32'h0000_0000, m, e, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, 32'h0000_0000, 32'h0000_0000, r);
  endtask

  task automatic wait_state(input ccs_state_t s, input int bound);
    logic [31:0] r;
    int k;
    for (k = 0; k < bound; k++) begin
      wb(1'h0, 8'h04, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, r);
      if (r[8:0] === s) break;
    end
    if (k == bound) fail("state wait timeout");
    rd(8'h04, 32'h0000_01ff, {23'h0, s});
  endtask

  // monitor: every acknowledged access retires the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'h1) begin
      note = notes.pop_front();
      if (note[63:32] !== 32'h0000_0000) begin
        total_checks++;
        if ((dat_o & note[63:32]) !== note[31:0]) begin
          num_errors++;
          $display("Error at %0t: read %h expected %h", $time, dat_o & note[63:32], note[31:0]);
        end
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fail("run timeout");
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(8'h04, 32'h0000_01ff, 32'h0000_0001);
    rd(8'h00, 32'hffff_ffff, 32'h0000_0000);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'hffff_ffff, 32'h0000_0000);
    supply_valid_i <= 1'h1;
    wait_state(CCS_STANDBY, 20);
    thermistor_input_test_i <= 1'h1;
    thermistor_input_high_i <= 1'h1;
    wait_state(CCS_TEST, 20);
    thermistor_input_test_i <= 1'h0;
    thermistor_input_high_i <= 1'h0;
    wait_state(CCS_STANDBY, 20);
    supply_above_reg_i <= 1'h1;
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      ac_present_i <= rnd[0];
      usb_range_select_i <= rnd[1];
      repeat (8) @(posedge clk_i);
      rd(8'h04, 32'h0000_0800, {20'h0, rnd[0], 11'h0});
    end
    inserted <= 1'h1;
    wait_state(CCS_PRECOND, 20);
    wait_state(CCS_CONST_CURR, 40);
    wait_state(CCS_CONST_VOLT, 40);
    wait_state(CCS_COMPLETE, 40);
    rd(8'h04, 32'h0000_0200, 32'h0000_0200);
    wr(8'h00, 32'h0000_0001);
    wait_state(CCS_STANDBY, 20);
    wr(8'h00, 32'h0000_0000);
    wait_state(CCS_COMPLETE, 20);
    stall <= 1'h1;
    drain <= 1'h1;
    @(posedge clk_i);
    drain <= 1'h0;
    wait_state(CCS_CONST_CURR, 20);
    thermistor_input_low_i <= 1'h1;
    wait_state(CCS_TEMP_FAULT, 20);
    rd(8'h04, 32'h0000_0400, 32'h0000_0000);
    thermistor_input_low_i <= 1'h0;
    wait_state(CCS_CONST_CURR, 20);
    wait_state(CCS_TIMER_FAULT, 4000);
    current_set_open_i <= 1'h1;
    wait_state(CCS_STANDBY, 20);
    give_verdict();
  end
endmodule // ccs_charge_ctrl_tb

bind ccs_charge_ctrl ccs_charge_ctrl_sva #(.PRECOND_PCT(PRECOND_PCT), .TERM_PCT(TERM_PCT)) i_sva (.*);
